// ===== common/pwm_pkg.sv
// constants shared by the complementary pwm generator and its dead-time unit
// assumes a 32-bit apb register bus with word-aligned byte addresses
package pwm_pkg;

    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int GC_W = 10;
    localparam int OC_W = 10;

    // register byte addresses
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_DUTY = 8'h0c;
    localparam logic [7:0] ADDR_DEAD = 8'h10;
    localparam logic [7:0] ADDR_ALT_DEAD = 8'h14;
    localparam logic [7:0] ADDR_TB_EN = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // generator_control_register fields
    localparam int GC_IMMEDIATE = 0;
    localparam int GC_CENTER = 2;
    localparam int GC_ITB = 9;

    // output_control_register fields
    localparam int OC_SYNC = 0;
    localparam int OC_DATA_LOW = 6;
    localparam int OC_DATA_HIGH = 7;
    localparam int OC_EN_LOW = 8;
    localparam int OC_EN_HIGH = 9;

    // time base enable and status fields
    localparam int TB_EN_BIT = 0;
    localparam int ST_HIGH = 16;
    localparam int ST_LOW = 17;
    localparam int ST_DT_ACTIVE = 18;
    localparam int ST_DOWN = 19;

    // reset values
    localparam logic [GC_W-1:0] GEN_CTRL_RST = 10'h000;
    localparam logic [OC_W-1:0] OUT_CTRL_RST = 10'h000;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0100;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DEAD_RST = 16'h0000;

    // center-aligned compare offset: count + 2 <= duty means high
    localparam logic [CNT_W:0] CENTER_OFFSET = 17'h00002;

endpackage : pwm_pkg

// ===== hdl/pwm_dead_time.sv
// dead-time unit: turns one raw high-side level into two gated outputs
// assumes the caller gives single-cycle bypass/cut pulses and a hold level
`timescale 1ns/1ps
`default_nettype none

module pwm_dead_time #(
    parameter int W = pwm_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic raw_high,
    input wire logic retrigger,
    input wire logic bypass,
    input wire logic cut,
    input wire logic hold,
    input wire logic [W-1:0] dt_high,
    input wire logic [W-1:0] dt_low,
    output logic [1:0] gate,
    output logic active
);

    typedef struct packed {
        logic [1:0][W-1:0] cnt;
        logic [1:0] prev;
        logic [1:0] gate;
    } dt_state_t;

    dt_state_t s;
    dt_state_t next_s;
    logic [1:0] want;
    logic [1:0] load;
    logic [1:0][W-1:0] dt_sel;
    logic [1:0][W-1:0] next_cnt;
    logic [1:0] next_gate;

    // channel 0 is the high side, channel 1 the complementary low side
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        assign want[ch] = (ch == 0) ? raw_high : !raw_high;
        assign dt_sel[ch] = (ch == 0) ? dt_high : dt_low;
        // boundary retrigger reloads dead time on a held output
        assign load[ch] = want[ch] & (!s.prev[ch] | (retrigger & (dt_sel[ch] != '0)));
        // immediate change or late write drops the delay
        assign next_cnt[ch] = (hold | bypass | cut | !want[ch]) ? '0 :
                              load[ch] ? dt_sel[ch] :
                              (s.cnt[ch] != '0) ? s.cnt[ch] - 1'b1 : s.cnt[ch];
        // an output asserts after its counter drained, or at once on bypass or cut
        assign next_gate[ch] = !hold & want[ch] &
                               (bypass | cut | (!load[ch] & (next_cnt[ch] == '0)));
    end

    // next state
    always_comb begin
        next_s = s;
        next_s.cnt = next_cnt;
        next_s.prev = hold ? 2'b00 : want;
        next_s.gate = next_gate;
    end

    // registered state, frozen while ce is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign gate = s.gate;
    assign active = (s.cnt[0] != '0) | (s.cnt[1] != '0);

endmodule : pwm_dead_time
`default_nettype wire

// ===== hdl/complementary_pwm_deadtime_override.sv
// complementary pwm generator with dead time, immediate update and override
// assumes an apb master on clk, and a shared master time base on the ports
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module complementary_pwm_deadtime_override #(
    parameter int CNT_W = pwm_pkg::CNT_W,
    parameter bit EARLY_REVISION = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwm_pkg::DATA_W-1:0] pwdata,
    output logic [pwm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CNT_W-1:0] master_count,
    input wire logic master_boundary,
    output logic high_side_output,
    output logic low_side_output
);

    typedef struct packed {
        logic [pwm_pkg::GC_W-1:0] gen_ctrl;
        logic [pwm_pkg::OC_W-1:0] out_ctrl;
        logic time_base_enable;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty_new;
        logic [CNT_W-1:0] duty_active;
        logic [CNT_W-1:0] dead;
        logic [CNT_W-1:0] alt_dead;
        logic [CNT_W-1:0] count;
        logic down;
        logic [3:0] ovr;
        logic high;
        logic low;
        logic pend_bypass;
        logic pend_cut;
        logic [pwm_pkg::DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } pwm_state_t;

    pwm_state_t s;
    pwm_state_t next_s;

    logic immediate;
    logic center;
    logic independent_time_base_select;
    logic [CNT_W-1:0] cmp_count;
    logic own_boundary;
    logic boundary;
    logic retrig;
    logic raw_high;
    logic force_narrow;
    logic between;
    logic bypass;
    logic cut;
    logic wr_en;
    logic [CNT_W-1:0] wr_cnt;
    logic [pwm_pkg::OC_W-1:0] wr_oc;
    logic release_req;
    logic [pwm_pkg::CNT_W:0] center_sum;
    logic [CNT_W-1:0] duty_lo;
    logic [CNT_W-1:0] duty_hi;
    logic [1:0] gate;
    logic dt_active;
    logic [pwm_pkg::DATA_W-1:0] rd_value;
    logic rd_hit;

    assign immediate = s.gen_ctrl[pwm_pkg::GC_IMMEDIATE];
    assign center = s.gen_ctrl[pwm_pkg::GC_CENTER];
    assign independent_time_base_select = s.gen_ctrl[pwm_pkg::GC_ITB];
    // own counter or the shared master count
    assign cmp_count = independent_time_base_select ? s.count : master_count;
    assign boundary = independent_time_base_select ? own_boundary : master_boundary;
    // dead-time reload at period start; the edge base ends its period at the top count,
    // and reloading there would stretch the normal high-side gap
    assign retrig = independent_time_base_select ? (s.time_base_enable && (s.count == '0)) : master_boundary;

    // own time base: edge counts up and wraps, center counts up then down
    always_comb begin
        own_boundary = 1'b0;
        if (s.time_base_enable) begin
            if (center) begin
                own_boundary = s.down && (s.count == '0);
            end else begin
                own_boundary = (s.count >= s.period);
            end
        end
    end

    // raw compare; center needs period+2 and edge period+1 for full duty
    assign center_sum = {1'b0, cmp_count} + pwm_pkg::CENTER_OFFSET;
    assign raw_high = s.time_base_enable &&
                      (center ? (center_sum <= {1'b0, s.duty_active})
                              : (cmp_count < s.duty_active));

    // small center duty under independent time base
    assign force_narrow = center && independent_time_base_select &&
                          ({s.duty_active, 1'b0} < {1'b0, s.alt_dead});

    // apb decode; the write is taken in the access cycle with pready high
    assign wr_en = psel && penable && pwrite && s.pready;
    assign wr_cnt = pwdata[CNT_W-1:0];
    assign wr_oc = pwdata[pwm_pkg::OC_W-1:0];
    assign duty_lo = (wr_cnt < s.duty_active) ? wr_cnt : s.duty_active;
    assign duty_hi = (wr_cnt < s.duty_active) ? s.duty_active : wr_cnt;
    // count lying between previous_duty_value and new_duty_value
    assign between = (cmp_count >= duty_lo) && (cmp_count < duty_hi);
    assign release_req = (s.out_ctrl[pwm_pkg::OC_EN_HIGH] && !wr_oc[pwm_pkg::OC_EN_HIGH]) ||
                         (s.out_ctrl[pwm_pkg::OC_EN_LOW] && !wr_oc[pwm_pkg::OC_EN_LOW]);

    // immediate duty writes bypass or cut the dead-time delay
    always_comb begin
        bypass = 1'b0;
        cut = 1'b0;
        if (wr_en && (paddr == pwm_pkg::ADDR_DUTY) && immediate && s.time_base_enable) begin
            bypass = between;
            cut = dt_active && !between;
        end
    end

    // dead-time unit: center uses the alternate value on both edges
    pwm_dead_time #(
        .W(CNT_W)
    ) u_dead_time (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .raw_high(raw_high),
        .retrigger(retrig),
        .bypass(s.pend_bypass),
        .cut(s.pend_cut),
        .hold(!s.time_base_enable),
        .dt_high(center ? s.alt_dead : s.dead),
        .dt_low(s.alt_dead),
        .gate(gate),
        .active(dt_active)
    );

    // read mux
    always_comb begin
        rd_value = '0;
        rd_hit = 1'b1;
        case (paddr)
            pwm_pkg::ADDR_GEN_CTRL: begin
                rd_value[pwm_pkg::GC_W-1:0] = s.gen_ctrl;
            end
            pwm_pkg::ADDR_OUT_CTRL: begin
                rd_value[pwm_pkg::OC_W-1:0] = s.out_ctrl;
            end
            pwm_pkg::ADDR_PERIOD: begin
                rd_value[CNT_W-1:0] = s.period;
            end
            pwm_pkg::ADDR_DUTY: begin
                rd_value[CNT_W-1:0] = s.duty_new;
            end
            pwm_pkg::ADDR_DEAD: begin
                rd_value[CNT_W-1:0] = s.dead;
            end
            pwm_pkg::ADDR_ALT_DEAD: begin
                rd_value[CNT_W-1:0] = s.alt_dead;
            end
            pwm_pkg::ADDR_TB_EN: begin
                rd_value[pwm_pkg::TB_EN_BIT] = s.time_base_enable;
            end
            pwm_pkg::ADDR_STATUS: begin
                rd_value[CNT_W-1:0] = cmp_count;
                rd_value[pwm_pkg::ST_HIGH] = s.high;
                rd_value[pwm_pkg::ST_LOW] = s.low;
                rd_value[pwm_pkg::ST_DT_ACTIVE] = dt_active;
                rd_value[pwm_pkg::ST_DOWN] = s.down;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // next state: time base, duty load, bus, override, outputs
    always_comb begin
        next_s = s;

        // own time base runs only while enabled
        if (!s.time_base_enable) begin
            next_s.count = '0;
            next_s.down = 1'b0;
        end else if (center) begin
            if (!s.down) begin
                if (s.count >= s.period) begin
                    next_s.down = 1'b1;
                    next_s.count = s.count - 1'b1;
                end else begin
                    next_s.count = s.count + 1'b1;
                end
            end else if (s.count == '0) begin
                next_s.down = 1'b0;
                next_s.count = s.count + 1'b1;
            end else begin
                next_s.count = s.count - 1'b1;
            end
        end else if (s.count >= s.period) begin
            next_s.count = '0;
        end else begin
            next_s.count = s.count + 1'b1;
        end

        // buffered duty takes effect on the period boundary
        if (boundary && !immediate) begin
            next_s.duty_active = s.duty_new;
        end

        // apb: zero-wait answer registered from the setup cycle
        next_s.pready = psel && !penable;
        if (psel && !penable) begin
            next_s.prdata = pwrite ? '0 : rd_value;
            next_s.pslverr = !rd_hit;
        end else begin
            next_s.pslverr = 1'b0;
        end

        if (wr_en) begin
            case (paddr)
                pwm_pkg::ADDR_GEN_CTRL: begin
                    next_s.gen_ctrl = pwdata[pwm_pkg::GC_W-1:0];
                end
                pwm_pkg::ADDR_OUT_CTRL: begin
                    // release near dead time is dropped on early parts
                    if (!(EARLY_REVISION && dt_active && release_req)) begin
                        next_s.out_ctrl = wr_oc;
                    end
                end
                pwm_pkg::ADDR_PERIOD: begin
                    next_s.period = wr_cnt;
                end
                pwm_pkg::ADDR_DUTY: begin
                    next_s.duty_new = wr_cnt;
                    if (immediate) begin
                        next_s.duty_active = wr_cnt;
                    end
                end
                pwm_pkg::ADDR_DEAD: begin
                    next_s.dead = wr_cnt;
                end
                pwm_pkg::ADDR_ALT_DEAD: begin
                    next_s.alt_dead = wr_cnt;
                end
                pwm_pkg::ADDR_TB_EN: begin
                    next_s.time_base_enable = pwdata[pwm_pkg::TB_EN_BIT];
                end
                default: begin
                end
            endcase
        end

        // compare sees the new duty one cycle after the write, so the bypass waits for it
        next_s.pend_bypass = bypass;
        next_s.pend_cut = cut;

        // override applies at once, or at the boundary when synchronised and the time base is enabled
        if (!s.out_ctrl[pwm_pkg::OC_SYNC] || boundary || !s.time_base_enable) begin
            next_s.ovr = s.out_ctrl[pwm_pkg::OC_EN_HIGH:pwm_pkg::OC_DATA_LOW];
        end

        // output pins; override data bit 7 is high side, bit 6 low side
        if (s.ovr[3]) begin
            next_s.high = s.ovr[1];
        end else if (force_narrow) begin
            next_s.high = raw_high;
        end else begin
            next_s.high = gate[0];
        end
        if (s.ovr[2]) begin
            next_s.low = s.ovr[0];
        end else if (force_narrow) begin
            next_s.low = 1'b0;
        end else begin
            next_s.low = gate[1];
        end
    end

    // state register; ce low freezes everything including the bus answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.gen_ctrl <= pwm_pkg::GEN_CTRL_RST;
            s.out_ctrl <= pwm_pkg::OUT_CTRL_RST;
            s.period <= pwm_pkg::PERIOD_RST;
            s.duty_new <= pwm_pkg::DUTY_RST;
            s.duty_active <= pwm_pkg::DUTY_RST;
            s.dead <= pwm_pkg::DEAD_RST;
            s.alt_dead <= pwm_pkg::DEAD_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign high_side_output = s.high;
    assign low_side_output = s.low;

endmodule : complementary_pwm_deadtime_override
`default_nettype wire

// ===== test/pwm_monitor.sv
// checker for the complementary pwm generator, on its ports only
// assumes a bind from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pwm_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwm_pkg::DATA_W-1:0] pwdata,
    input wire logic [pwm_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CNT_W-1:0] master_count,
    input wire logic master_boundary,
    input wire logic high_side_output,
    input wire logic low_side_output
);
    logic wr, odd, ovr_on, tb_on, oh, ol;
    // writes as the slave takes them
    assign wr = psel && penable && pready && pwrite && ce;
    // shadows; odd sticks once immediate or override was used
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {odd, ovr_on, tb_on, oh, ol} <= 5'h0;
        end else if (wr) begin
            if (paddr == pwm_pkg::ADDR_GEN_CTRL && pwdata[0]) begin
                odd <= 1'b1;
            end
            if (paddr == pwm_pkg::ADDR_OUT_CTRL) begin
                odd <= odd || (|pwdata[9:8]);
                ovr_on <= |pwdata[9:8];
                oh <= pwdata[7];
                ol <= pwdata[6];
            end
            if (paddr == pwm_pkg::ADDR_TB_EN) begin
                tb_on <= pwdata[0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence setup_s;
        psel && !penable && ce;
    endsequence
    sequence ovr_wr_s;
        wr && paddr == pwm_pkg::ADDR_OUT_CTRL && pwdata[9:8] == 2'h3 && !pwdata[0];
    endsequence
    sequence settle_s;
        (ce && !penable)[*3];
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("no answer after setup");
    ready_one_cycle_a: assert property (pready && ce |=> !pready)
        else $error("answer held too long");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable && ce))
        else $error("answer without setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    err_zero_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    gap_high_a: assert property ($rose(high_side_output) && !odd |->
        !$past(low_side_output)) else $error("high rose with no gap");
    gap_low_a: assert property ($rose(low_side_output) && !odd |->
        !$past(high_side_output)) else $error("low rose with no gap");
    ovr_drive_a: assert property (ovr_wr_s ##1 settle_s |->
        high_side_output == oh && low_side_output == ol) else $error("override levels");
    idle_low_a: assert property ((!tb_on && !ovr_on && ce)[*4] |->
        !high_side_output && !low_side_output) else $error("outputs on while idle");
endmodule : pwm_monitor
`default_nettype wire

// ===== test/gate_driver_model.sv
// gate driver model: watches both gate lines and measures their timing
// assumes registered gate lines on clk
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic gate_high,
    input wire logic gate_low,
    output logic [15:0] gap_h,
    output logic [15:0] gap_l,
    output logic [15:0] width_h,
    output logic [15:0] flips,
    output logic [15:0] overlap,
    output logic [15:0] cnt_h,
    output logic [15:0] cnt_l
);
    logic hq, lq;
    logic [15:0] off_run, on_run;
    // overlap would short the bridge, so it is only counted for the bench
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {hq, lq, off_run, on_run, gap_h, gap_l, width_h, flips} <= '0;
            {overlap, cnt_h, cnt_l} <= '0;
        end else begin
            hq <= gate_high;
            lq <= gate_low;
            off_run <= (!gate_high && !gate_low) ? off_run + 16'h1 : 16'h0;
            on_run <= gate_high ? on_run + 16'h1 : 16'h0;
            cnt_h <= cnt_h + {15'h0, gate_high};
            cnt_l <= cnt_l + {15'h0, gate_low};
            gap_h <= (gate_high && !hq) ? off_run : gap_h;
            gap_l <= (gate_low && !lq) ? off_run : gap_l;
            width_h <= (!gate_high && hq) ? on_run : width_h;
            flips <= flips + {15'h0, gate_high && !hq && !gate_low && lq};
            overlap <= overlap + {15'h0, gate_high && gate_low};
        end
    end
endmodule : gate_driver_model
`default_nettype wire

// ===== test/testbench.sv
// bench for the pwm generator: apb tasks, table tests, gate model
// assumes the design package is compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int P = 20;
    typedef struct packed {
        logic [9:0] gc;
        logic [15:0] dt;
        logic [15:0] alt;
        logic [15:0] duty;
        logic [1:0] eh;
        logic [1:0] el;
    } row_t;
    logic clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, mb, hs, ls, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mc, gap_h, gap_l, width_h, flips, overlap, cnt_h, cnt_l, f0;
    int n_errors = 0;
    int n_checks = 0;
    int nh, nl;
    // 2'h3 means no expectation on that side
    row_t rows [8] = '{
        '{10'h000, 16'h3, 16'h3, 16'h0, 2'h0, 2'h2},
        '{10'h200, 16'h3, 16'h3, 16'h0, 2'h0, 2'h2},
        '{10'h200, 16'h3, 16'h3, 16'h14, 2'h2, 2'h3},
        '{10'h200, 16'h0, 16'h0, 16'h0, 2'h0, 2'h1},
        '{10'h200, 16'h0, 16'h0, 16'h15, 2'h1, 2'h0},
        '{10'h204, 16'h3, 16'h0, 16'h0, 2'h0, 2'h1},
        '{10'h204, 16'h3, 16'h0, 16'h16, 2'h1, 2'h0},
        '{10'h204, 16'h0, 16'ha, 16'h2, 2'h2, 2'h0}
    };
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0, 32'h0};
    complementary_pwm_deadtime_override i_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_count(mc),
        .master_boundary(mb), .high_side_output(hs), .low_side_output(ls));
    gate_driver_model i_gate (.clk(clk), .reset_n(reset_n), .gate_high(hs), .gate_low(ls),
        .gap_h(gap_h), .gap_l(gap_l), .width_h(width_h), .flips(flips),
        .overlap(overlap), .cnt_h(cnt_h), .cnt_l(cnt_l));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // shared master time base, period P
    always @(posedge clk) begin
        if (!reset_n) begin
            mc <= 16'h0;
            mb <= 1'b0;
        end else begin
            mc <= (mc == 16'(P)) ? 16'h0 : mc + 16'h1;
            mb <= (mc == 16'(P));
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // setup, access until pready at an edge, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        n_errors += (n >= 50) ? 1 : 0;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task measure;
        logic [15:0] h0, l0;
        h0 = cnt_h;
        l0 = cnt_l;
        repeat (2 * P) @(posedge clk);
        nh = int'(cnt_h - h0);
        nl = int'(cnt_l - l0);
    endtask : measure
    function automatic logic [1:0] cls(input int n);
        return (n == 0) ? 2'h0 : (n == 2 * P) ? 2'h1 : 2'h2;
    endfunction : cls
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        {reset_n, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (16) @(posedge clk);
        check("reset outputs", {29'h0, hs, ls, pready}, 32'h0);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", rd, rv[i]);
        end
        for (int w = 0; w < 2; w++) begin
            apb(w[0], 8'h20, 32'hffff);
            check("unmapped", {er, rd[30:0]}, 32'h80000000);
        end
        $display("registers done");
        wr(8'h08, P);
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h5);
        wr(8'h0c, 32'h8);
        wr(8'h00, 32'h200);
        wr(8'h18, 32'h1);
        repeat (100) @(posedge clk);
        check("gap before high", gap_h, 32'h3);
        check("gap before low", gap_l, 32'h5);
        check("high width", width_h, 32'h5);
        $display("dead time done");
        foreach (rows[i]) begin
            wr(8'h00, rows[i].gc);
            wr(8'h10, rows[i].dt);
            wr(8'h14, rows[i].alt);
            wr(8'h0c, rows[i].duty);
            repeat (100) @(posedge clk);
            measure();
            if (rows[i].eh != 2'h3) check("high share", cls(nh), rows[i].eh);
            if (rows[i].el != 2'h3) check("low share", cls(nl), rows[i].el);
        end
        $display("duty table done");
        wr(8'h08, 32'hc8);
        wr(8'h10, 32'h3);
        wr(8'h14, 32'h3);
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 32'h200 | m);
            wr(8'h0c, 32'h14);
            repeat (450) @(posedge clk);
            do apb(1'b0, 8'h1c, 32'h0); while (rd[15:0] < 16'h28 || rd[15:0] > 16'h64);
            f0 = flips;
            wr(8'h0c, 32'hb4);
            repeat (6) @(posedge clk);
            check("flip count", 32'(flips - f0), m);
            check("high after write", {31'h0, hs}, m);
        end
        $display("immediate done");
        wr(8'h08, P);
        wr(8'h0c, 32'h8);
        repeat (450) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, 32'h300 | ((k / 2 + 1) << 6) | (k % 2));
            repeat (2 * P + 10) @(posedge clk);
            check("override levels", {hs, ls}, k / 2 + 1);
        end
        wr(8'h18, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h18, 32'h1);
        repeat (100) @(posedge clk);
        measure();
        check("release shares", {cls(nh), cls(nl)}, 32'ha);
        check("overlap", overlap, 32'h0);
        $display("override done");
        stop_test();
    end
endmodule : testbench
bind complementary_pwm_deadtime_override pwm_monitor #(.CNT_W(CNT_W)) i_mon (.clk(clk),
    .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_count(master_count), .master_boundary(master_boundary),
    .high_side_output(high_side_output), .low_side_output(low_side_output));
`default_nettype wire
